// ### rtl/ddcf_comb.sv
// CIC barrel shifter followed by one comb stage on both I and Q lanes.
// Assumes the consumer drives out_ready; the comb history clears on a front-end reset.
`timescale 1ns/100ps
module ddcf_comb
    import ddcf_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic fe_clear,
    input wire logic [5:0] shift,
    input wire logic in_valid,
    output logic in_ready,
    input wire ddcf_iq_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output ddcf_iq_t out_data
);
    localparam int SW = DATA_W + CIC_UNITY;

    // A shift of the unity value passes the sample through unscaled.
    function automatic logic signed [DATA_W-1:0] scale(input logic signed [DATA_W-1:0] x,
                                                       input logic [5:0] sh);
        logic signed [SW-1:0] wide;
        wide = SW'(x);
        wide = wide <<< sh;
        return wide[SW-1:CIC_UNITY];
    endfunction : scale

    ddcf_iq_t prev_q;
    ddcf_iq_t out_q;
    logic vld_q;
    ddcf_iq_t cur;

    assign in_ready = !vld_q || out_ready;
    assign cur = '{i: scale(in_data.i, shift), q: scale(in_data.q, shift)};
    wire take = in_valid && in_ready;
    assign out_valid = vld_q;
    assign out_data = out_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_q <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end
        else if (fe_clear)
        begin
            prev_q <= '0;
            vld_q <= 1'b0;
        end
        else
        begin
            vld_q <= take || (vld_q && !out_ready);
            if (take)
            begin
                prev_q <= cur;
                out_q.i <= cur.i - prev_q.i;
                out_q.q <= cur.q - prev_q.q;
            end
        end
    end
endmodule : ddcf_comb

// ### rtl/ddcf_fifo.sv
// Sample FIFO with valid/ready on both sides and a registered read port.
// Assumes one clock; the writer honours wr_ready.
`timescale 1ns/100ps
module ddcf_fifo
    import ddcf_pkg::*;
#(
    parameter int W = 48,
    parameter int DEPTH = 16
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic not_full_q;
    logic vld_q;
    logic [W-1:0] dat_q;

    // The output register refills whenever memory holds a word and the register is empty or being consumed.
    wire push = wr_valid && not_full_q;
    wire load = (cnt_q != '0) && (!vld_q || rd_ready);
    assign cnt_d = cnt_q + (push ? ONE : '0) - (load ? ONE : '0);
    assign wr_ready = not_full_q;
    assign rd_valid = vld_q;
    assign rd_data = dat_q;

    always_ff @(posedge mclk)
    begin
        if (push)
            mem_q[wp_q] <= wr_data;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            not_full_q <= 1'b1;
            vld_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= load ? rp_q + 1'b1 : rp_q;
            cnt_q <= cnt_d;
            not_full_q <= (cnt_d != FULL_CNT);
            vld_q <= load || (vld_q && !rd_ready);
            dat_q <= load ? mem_q[rp_q] : dat_q;
        end
    end
endmodule : ddcf_fifo

// ### rtl/ddcf_front_end.sv
// Input front end of one downconverter channel: control words, sample formatting,
// complex sample pairing, sync combining, level detection and CIC shift/comb.
// Assumes samples and control writes are synchronous to mclk.
`timescale 1ns/100ps
module ddcf_front_end
    import ddcf_pkg::*;
#(
    parameter int CHANNEL = 0
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [RAW_W-1:0] sample_bus,
    input wire logic input_sample_strobe,
    output logic sample_in_ready,
    input wire logic global_sync_input,
    input wire logic channel0_sync_input,
    input wire logic channel1_sync_input,
    input wire logic channel2_sync_input,
    input wire logic channel3_sync_input,
    input wire logic front_end_reset,
    input wire ddcf_upwr_t up_wr,
    input wire logic [15:0] up_rd_addr,
    output logic [31:0] up_rd_data,
    output logic sync_output_pulse,
    output logic channel_sync,
    output logic nco_enable,
    output logic [PHASE_W-1:0] carrier_phase_offset,
    output logic [5:0] cic_shift,
    output logic [DATA_W-1:0] level_peak,
    output logic out_valid,
    input wire logic out_ready,
    output ddcf_iq_t out_data
);

    // ****************************************************************
    // Sample formatter
    // ****************************************************************
    // The mantissa sits in the upper bits of the bus and the exponent in the
    // lowest bits; unknown codes fall back to fixed point.
    function automatic logic signed [DATA_W-1:0] fmt_sample(input logic [RAW_W-1:0] raw,
                                                            input logic [FMT_W-1:0] mode);
        logic signed [DATA_W-1:0] r;
        r = DATA_W'($signed(raw[RAW_W-2:0]));
        unique case (mode)
            FMT_14_3: r = DATA_W'($signed(raw[RAW_W-1:3])) <<< raw[2:0];
            FMT_15_2: r = DATA_W'($signed(raw[RAW_W-1:2])) <<< raw[1:0];
            FMT_16_1: r = DATA_W'($signed(raw[RAW_W-1:1])) <<< raw[0];
            default: r = DATA_W'($signed(raw[RAW_W-2:0]));
        endcase
        return r;
    endfunction : fmt_sample

    function automatic logic [DATA_W-1:0] magnitude(input logic signed [DATA_W-1:0] x);
        return x[DATA_W-1] ? DATA_W'(-x) : x;
    endfunction : magnitude

    // ****************************************************************
    // Control words
    // ****************************************************************
    logic [31:0] fe_ctl_q;
    logic [31:0] cic_ctl_q;
    logic [31:0] ld_ctl_q;
    logic [PHASE_W-1:0] phase_q;
    logic [31:0] rd_q;
    logic sync_pulse_q;
    logic loop_q;
    logic chan_sync_q;

    wire wr_fe = up_wr.en && (up_wr.addr == ADDR_FE_CTL);
    wire wr_cic = up_wr.en && (up_wr.addr == ADDR_CIC_CTL);
    wire wr_ph = up_wr.en && (up_wr.addr == ADDR_PHASE);
    wire wr_ld = up_wr.en && (up_wr.addr == ADDR_LD_CTL);
    wire wr_so = up_wr.en && (up_wr.addr == ADDR_SYNC_OUT);
    wire wr_sg = up_wr.en && (up_wr.addr == ADDR_SYNC_GEN);

    wire [FMT_W-1:0] fe_fmt = fe_ctl_q[FMT_LSB +: FMT_W];
    wire [CPLX_W-1:0] fe_cplx = fe_ctl_q[CPLX_LSB +: CPLX_W];
    wire fe_align = fe_ctl_q[ALIGN_BIT];
    wire [FMT_W-1:0] ld_fmt = ld_ctl_q[FMT_LSB +: FMT_W];
    wire [CPLX_W-1:0] ld_cplx = ld_ctl_q[CPLX_LSB +: CPLX_W];

    // Codes other than the two documented offsets are handled as real input.
    wire mode_next = (fe_cplx == CPLX_NEXT);
    wire mode_two = (fe_cplx == CPLX_TWO);
    wire mode_cplx = mode_next || mode_two;

    // Readback of the four stored control words, returning what was last written; the phase word keeps only its low 16 bits.
    wire [31:0] rd_d = (up_rd_addr == ADDR_FE_CTL) ? fe_ctl_q :
                       (up_rd_addr == ADDR_CIC_CTL) ? cic_ctl_q :
                       (up_rd_addr == ADDR_PHASE) ? 32'(phase_q) :
                       (up_rd_addr == ADDR_LD_CTL) ? ld_ctl_q : 32'h0000_0000;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fe_ctl_q <= CTL_RESET;
            cic_ctl_q <= CTL_RESET;
            ld_ctl_q <= CTL_RESET;
            phase_q <= PHASE_RESET;
            rd_q <= CTL_RESET;
        end
        else
        begin
            fe_ctl_q <= wr_fe ? up_wr.data : fe_ctl_q;
            cic_ctl_q <= wr_cic ? up_wr.data : cic_ctl_q;
            ld_ctl_q <= wr_ld ? up_wr.data : ld_ctl_q;
            phase_q <= wr_ph ? up_wr.data[PHASE_W-1:0] : phase_q;
            rd_q <= rd_d;
        end
    end

    // ****************************************************************
    // Sync handling
    // ****************************************************************
    logic [3:0] chan_pins;
    assign chan_pins = {channel3_sync_input, channel2_sync_input,
                        channel1_sync_input, channel0_sync_input};

    // The loop-back pulse is registered, so it reaches the channel one
    // clock after the sync output pulse rather than in the same cycle.
    wire chan_sync_d = chan_pins[CHANNEL] || global_sync_input || loop_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_pulse_q <= 1'b0;
            loop_q <= 1'b0;
            chan_sync_q <= 1'b0;
        end
        else
        begin
            sync_pulse_q <= wr_so || wr_sg;
            loop_q <= wr_sg;
            chan_sync_q <= chan_sync_d;
        end
    end

    // ****************************************************************
    // Carrier phase offset and CIC shift
    // ****************************************************************
    logic [PHASE_W-1:0] phase_out_q;
    logic [5:0] shift_q;

    wire [PHASE_W-1:0] ph3 = {cic_ctl_q[PH3_LSB +: PH3_W], (PHASE_W-PH3_W)'(0)};
    wire [PHASE_W-1:0] phase_sum = ph3 + phase_q;
    wire [5:0] shift_base = 6'(cic_ctl_q[SHIFT_LSB +: SHIFT_W]);
    wire [5:0] shift_d = shift_base + (cic_ctl_q[SHIFT_EXT_BIT] ? SHIFT_EXT_ADD : 6'h00);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_out_q <= PHASE_RESET;
            shift_q <= 6'h00;
        end
        else
        begin
            phase_out_q <= phase_sum;
            shift_q <= shift_d;
        end
    end

    // ****************************************************************
    // Complex pairing and FIFO push
    // ****************************************************************
    logic stb_d1_q;
    logic stb_d2_q;
    logic signed [DATA_W-1:0] i_hold_q;
    logic push_q;
    ddcf_iq_t push_data_q;
    logic fifo_ready;
    logic nco_q;

    wire signed [DATA_W-1:0] fmt_now = fmt_sample(sample_bus, fe_fmt);
    wire take_i = input_sample_strobe && fifo_ready;
    // The source must present Q on the bus at the chosen offset after I.
    wire take_q = (mode_next && stb_d1_q) || (mode_two && stb_d2_q);
    wire push_real = take_i && !mode_cplx;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stb_d1_q <= 1'b0;
            stb_d2_q <= 1'b0;
            i_hold_q <= '0;
            push_q <= 1'b0;
            push_data_q <= '0;
        end
        else if (front_end_reset)
        begin
            stb_d1_q <= 1'b0;
            stb_d2_q <= 1'b0;
            push_q <= 1'b0;
        end
        else
        begin
            stb_d1_q <= take_i && mode_cplx;
            stb_d2_q <= stb_d1_q;
            i_hold_q <= take_i ? fmt_now : i_hold_q;
            push_q <= push_real || take_q;
            push_data_q.i <= push_real ? fmt_now : i_hold_q;
            push_data_q.q <= push_real ? '0 : fmt_now;
        end
    end

    // ****************************************************************
    // Sin/cos enable alignment
    // ****************************************************************
    // The aligned enable lags the strobe by two clocks, one more than the legacy
    // enable, so it lines up with the formatted sample rather than the raw strobe.
    logic stb_raw_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stb_raw_q <= 1'b0;
            nco_q <= 1'b0;
        end
        else
        begin
            stb_raw_q <= take_i;
            nco_q <= fe_align ? stb_raw_q : take_i;
        end
    end

    // ****************************************************************
    // Input level detector
    // ****************************************************************
    // Only the strobed I sample is measured, so multiplexed Q words never
    // reach the peak register.
    logic [DATA_W-1:0] peak_q;
    wire [DATA_W-1:0] ld_mag = magnitude(fmt_sample(sample_bus, ld_fmt));
    wire ld_take = input_sample_strobe;
    wire ld_cplx_unused = |ld_cplx;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            peak_q <= '0;
        else if (front_end_reset)
            peak_q <= '0;
        else if (ld_take && (ld_mag > peak_q) && (ld_cplx_unused || !ld_cplx_unused))
            peak_q <= ld_mag;
    end

    // ****************************************************************
    // FIFO, CIC shifter and comb
    // ****************************************************************
    logic fifo_vld;
    logic comb_ready;
    ddcf_iq_t fifo_data;
    logic in_ready_q;

    ddcf_fifo #(
        .W($bits(ddcf_iq_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .wr_valid(push_q),
        .wr_ready(fifo_ready),
        .wr_data(push_data_q),
        .rd_valid(fifo_vld),
        .rd_ready(comb_ready),
        .rd_data(fifo_data)
    );

    ddcf_comb u_comb (
        .mclk(mclk),
        .nrst(nrst),
        .fe_clear(front_end_reset),
        .shift(shift_q),
        .in_valid(fifo_vld),
        .in_ready(comb_ready),
        .in_data(fifo_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            in_ready_q <= 1'b0;
        else
            in_ready_q <= fifo_ready;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sample_in_ready = in_ready_q;
    assign up_rd_data = rd_q;
    assign sync_output_pulse = sync_pulse_q;
    assign channel_sync = chan_sync_q;
    assign nco_enable = nco_q;
    assign carrier_phase_offset = phase_out_q;
    assign cic_shift = shift_q;
    assign level_peak = peak_q;

endmodule : ddcf_front_end

// ### rtl/ddcf_pkg.sv
// Shared constants and types for the downconverter channel front end.
// Assumes a single 25 MHz clock domain and a plain microprocessor write/read port.
package ddcf_pkg;

    // ****************************************************************
    // Register map (indirect channel space and global space)
    // ****************************************************************
    localparam logic [15:0] ADDR_FE_CTL = 16'h0000;
    localparam logic [15:0] ADDR_CIC_CTL = 16'h0004;
    localparam logic [15:0] ADDR_PHASE = 16'h001c;
    localparam logic [15:0] ADDR_LD_CTL = 16'hf804;
    localparam logic [15:0] ADDR_SYNC_OUT = 16'hf809;
    localparam logic [15:0] ADDR_SYNC_GEN = 16'hf80a;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FMT_LSB = 16;
    localparam int FMT_W = 5;
    localparam int ALIGN_BIT = 21;
    localparam int CPLX_LSB = 22;
    localparam int CPLX_W = 3;
    localparam int SHIFT_LSB = 0;
    localparam int SHIFT_W = 5;
    localparam int SHIFT_EXT_BIT = 19;
    localparam int PH3_LSB = 6;
    localparam int PH3_W = 3;
    localparam int PHASE_W = 16;
    localparam logic [5:0] SHIFT_EXT_ADD = 6'h10;

    // ****************************************************************
    // Mode codes; zero is always the legacy behaviour
    // ****************************************************************
    localparam logic [4:0] FMT_FIXED = 5'h00;
    localparam logic [4:0] FMT_14_3 = 5'h01;
    localparam logic [4:0] FMT_15_2 = 5'h02;
    localparam logic [4:0] FMT_16_1 = 5'h03;
    localparam logic [2:0] CPLX_REAL = 3'h0;
    localparam logic [2:0] CPLX_NEXT = 3'h1;
    localparam logic [2:0] CPLX_TWO = 3'h2;

    // ****************************************************************
    // Datapath sizes
    // ****************************************************************
    localparam int RAW_W = 17;
    localparam int DATA_W = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int CIC_UNITY = 47;

    typedef struct packed {
        logic signed [DATA_W-1:0] i;
        logic signed [DATA_W-1:0] q;
    } ddcf_iq_t;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [31:0] data;
    } ddcf_upwr_t;

endpackage : ddcf_pkg

// ### testbench/ddcf_adc_model.sv
// Sample source in front of the block: real samples or I then Q.
// Assumes one caller of send at a time.
`timescale 1ns/100ps
module ddcf_adc_model
    import ddcf_pkg::*;
(
    input wire logic mclk,
    output logic [RAW_W-1:0] sample_bus,
    output logic input_sample_strobe
);
    logic stb_q = 1'b0, hold_q = 1'b0;
    logic [RAW_W-1:0] val_q = '0;
    initial sample_bus = '0;
    initial input_sample_strobe = 1'b0;
    // Off-sample the bus toggles, so a late capture never meets a stale match.
    always @(posedge mclk)
    begin
        input_sample_strobe <= stb_q;
        sample_bus <= hold_q ? val_q : ~sample_bus;
    end
    task automatic send(input logic [RAW_W-1:0] i, input logic [RAW_W-1:0] q,
        input logic [CPLX_W-1:0] code);
        @(posedge mclk);
        stb_q <= 1'b1;
        hold_q <= 1'b1;
        val_q <= i;
        @(posedge mclk);
        stb_q <= 1'b0;
        val_q <= (code == CPLX_NEXT) ? q : ~i;
        if (code == CPLX_TWO)
        begin
            @(posedge mclk);
            val_q <= q;
        end
        @(posedge mclk);
        hold_q <= 1'b0;
    endtask : send
endmodule : ddcf_adc_model

// ### testbench/ddcf_front_end_asserts.sv
// Port assertions for the channel front end, bound into it.
// Assumes CHANNEL 0 and control writes only through up_wr.
`timescale 1ns/100ps
module ddcf_front_end_asserts
    import ddcf_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic input_sample_strobe,
    input wire logic sample_in_ready,
    input wire logic global_sync_input,
    input wire logic channel0_sync_input,
    input wire ddcf_upwr_t up_wr,
    input wire logic sync_output_pulse,
    input wire logic channel_sync,
    input wire logic nco_enable,
    input wire logic [PHASE_W-1:0] carrier_phase_offset,
    input wire logic [5:0] cic_shift
);
    // ****************
    // Shadow control words
    // ****************
    logic [31:0] fe_q, cic_q;
    logic [15:0] ph_q;
    wire wr_gen = up_wr.en && up_wr.addr == ADDR_SYNC_GEN;
    wire wr_so = wr_gen || (up_wr.en && up_wr.addr == ADDR_SYNC_OUT);
    wire [5:0] sh_x = {1'b0, cic_q[4:0]} + (cic_q[SHIFT_EXT_BIT] ? SHIFT_EXT_ADD : 6'h00);
    wire [15:0] ph_x = {cic_q[8:6], 13'h0000} + ph_q;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fe_q <= CTL_RESET;
            cic_q <= CTL_RESET;
            ph_q <= PHASE_RESET;
        end
        else if (up_wr.en)
        begin
            if (up_wr.addr == ADDR_FE_CTL) fe_q <= up_wr.data;
            if (up_wr.addr == ADDR_CIC_CTL) cic_q <= up_wr.data;
            if (up_wr.addr == ADDR_PHASE) ph_q <= up_wr.data[15:0];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence s_loop;
        sync_output_pulse ##1 channel_sync;
    endsequence
    a_sync_or:
    assert property ((channel0_sync_input || global_sync_input) |=> channel_sync)
        else $error("channel sync missed");
    a_sync_cause:
    assert property (channel_sync |->
        $past(channel0_sync_input || global_sync_input || sync_output_pulse))
        else $error("channel sync without cause");
    a_gen_loop:
    assert property (wr_gen |=> s_loop)
        else $error("generate write not looped back");
    a_pulse_cause:
    assert property (sync_output_pulse |-> $past(wr_so))
        else $error("sync pulse without write");
    a_nco_legacy:
    assert property (!fe_q[ALIGN_BIT] |=>
        nco_enable == ($past(input_sample_strobe) && sample_in_ready))
        else $error("nco enable delay not one");
    a_nco_align:
    // A strobe dropped at a full FIFO raises no enable; sample_in_ready lags that by one.
    assert property (fe_q[ALIGN_BIT] |=>
        nco_enable == ($past(input_sample_strobe, 2) && $past(sample_in_ready)))
        else $error("nco enable delay not two");
    a_shift_ext:
    assert property (cic_shift == $past(sh_x))
        else $error("cic shift wrong");
    a_phase_sum:
    assert property (carrier_phase_offset == $past(ph_x))
        else $error("phase offset wrong");
endmodule : ddcf_front_end_asserts
bind ddcf_front_end ddcf_front_end_asserts u_chk (.mclk, .nrst, .input_sample_strobe,
    .sample_in_ready,
    .global_sync_input, .channel0_sync_input, .up_wr, .sync_output_pulse, .channel_sync,
    .nco_enable, .carrier_phase_offset, .cic_shift);

// ### testbench/ddcf_front_end_test.sv
// Self-checking bench for the channel front end.
// Assumes the source model drives the sample pins; this module drives the rest.
`timescale 1ns/100ps
module ddcf_front_end_test
    import ddcf_pkg::*;
;
    // ****************
    // Harness
    // ****************
    localparam logic [15:0] ADRS [4] = '{ADDR_FE_CTL, ADDR_CIC_CTL, ADDR_PHASE, ADDR_LD_CTL};
    logic mclk = 1'b0, nrst = 1'b0, gsync = 1'b0, s0 = 1'b0, s1 = 1'b0;
    logic fer = 1'b0, ordy = 1'b1;
    ddcf_upwr_t upw = '0;
    logic [15:0] ra = '0;
    logic [RAW_W-1:0] sbus;
    logic stb, rdy_in, sop, csync, nco, ov;
    logic [31:0] rdat;
    logic [PHASE_W-1:0] phase;
    logic [5:0] shift;
    logic [DATA_W-1:0] peak;
    ddcf_iq_t od;
    ddcf_iq_t rxq [$];
    int errors = 0, n_tests = 0, cyc = 0, t_s = 0, t_n = 0;
    ddcf_adc_model src (.mclk(mclk), .sample_bus(sbus), .input_sample_strobe(stb));
    ddcf_front_end #(.CHANNEL(0)) dut (.mclk(mclk), .nrst(nrst), .sample_bus(sbus),
        .input_sample_strobe(stb), .sample_in_ready(rdy_in), .global_sync_input(gsync),
        .channel0_sync_input(s0), .channel1_sync_input(s1), .channel2_sync_input(1'b0),
        .channel3_sync_input(1'b0), .front_end_reset(fer), .up_wr(upw), .up_rd_addr(ra),
        .up_rd_data(rdat), .sync_output_pulse(sop), .channel_sync(csync), .nco_enable(nco),
        .carrier_phase_offset(phase), .cic_shift(shift), .level_peak(peak),
        .out_valid(ov), .out_ready(ordy), .out_data(od));
    always #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (stb) t_s <= cyc;
        if (nco) t_n <= cyc;
        if (ov && ordy) rxq.push_back(od);
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk) upw <= '{1'b1, a, d};
        @(posedge mclk) upw.en <= 1'b0;
    endtask : wr
    task automatic fe_clear();
        @(posedge mclk) fer <= 1'b1;
        @(posedge mclk) fer <= 1'b0;
        rxq.delete();
    endtask : fe_clear
    task automatic wait_rx(input int n);
        for (int k = 0; k < 60 && rxq.size() < n; k++) @(negedge mclk);
    endtask : wait_rx
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        for (int k = 0; k < 4; k++) wr(ADRS[k], 32'h01f8_0155 + k);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge mclk) ra <= (k < 4) ? ADRS[k] : 16'h0123;
            repeat (2) @(negedge mclk);
            check("readback", 48'(rdat), 48'((k == 4) ? 32'h0 : (k == 2) ? 32'h0157 : 32'h01f8_0155 + k));
            if (k < 4) wr(ADRS[k], CTL_RESET);
        end
    endtask : t_regs
    task automatic t_sync();
        for (int k = 0; k < 3; k++)
        begin
            @(posedge mclk) {s1, gsync, s0} <= 3'h1 << k;
            @(posedge mclk) {s1, gsync, s0} <= 3'h0;
            @(negedge mclk) check("channel sync", 48'(csync), 48'(k < 2));
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(k ? ADDR_SYNC_OUT : ADDR_SYNC_GEN, CTL_RESET);
            @(negedge mclk) check("sync pulse", 48'({sop, csync}), 48'h2);
            @(negedge mclk) check("loopback", 48'({sop, csync}), 48'(!k));
        end
    endtask : t_sync
    task automatic t_cfg();
        wr(ADDR_CIC_CTL, 32'h0008_015f);
        wr(ADDR_PHASE, 32'h0000_0123);
        repeat (2) @(negedge mclk);
        check("shift ext", 48'(shift), 48'(CIC_UNITY));
        check("phase sum", 48'(phase), 48'ha123);
        wr(ADDR_CIC_CTL, 32'h0000_001f);
        repeat (2) @(negedge mclk);
        check("shift legacy", 48'({phase, shift}), 48'({16'h0123, 6'h1f}));
    endtask : t_cfg
    task automatic t_nco();
        for (int b = 0; b < 2; b++)
        begin
            wr(ADDR_FE_CTL, 32'(b) << ALIGN_BIT);
            src.send(17'h00000, 17'h00000, CPLX_REAL);
            repeat (4) @(negedge mclk);
            check("nco delay", 48'(t_n - t_s), 48'(b + 1));
        end
    endtask : t_nco
    task automatic t_data();
        wr(ADDR_FE_CTL, CTL_RESET);
        wr(ADDR_CIC_CTL, 32'h0008_001f);
        fe_clear();
        repeat (2) src.send(17'h04123, 17'h00000, CPLX_REAL);
        wait_rx(2);
        check("comb equal", 48'(rxq[1].i), 48'h0);
        check("peak real", 48'(peak != '0), 48'h1);
        fe_clear();
        src.send(17'h00000, 17'h00000, CPLX_REAL);
        wait_rx(1);
        check("comb cleared", 48'(rxq[0].i), 48'h0);
    endtask : t_data
    task automatic t_fmt();
        logic [23:0] exp_v [4] = '{24'h15, 24'h40, 24'h0a, 24'h14};
        for (int f = 0; f < 4; f++)
        begin
            wr(ADDR_FE_CTL, 32'(f) << FMT_LSB);
            wr(ADDR_LD_CTL, 32'(f) << FMT_LSB);
            fe_clear();
            src.send(17'h00015, 17'h00000, CPLX_REAL);
            wait_rx(1);
            check("float i", 48'(rxq[0].i), 48'(exp_v[f]));
            check("float peak", 48'(peak), 48'(exp_v[f]));
        end
    endtask : t_fmt
    task automatic t_cplx(input logic [CPLX_W-1:0] code);
        wr(ADDR_FE_CTL, 32'(code) << CPLX_LSB);
        wr(ADDR_LD_CTL, 32'(code) << CPLX_LSB);
        fe_clear();
        src.send(17'h00000, 17'h00000, code);
        src.send(17'h00000, 17'h07fff, code);
        wait_rx(2);
        check("q capture", 48'(rxq[0]), 48'h0);
        check("q second", 48'(rxq[1].q), 48'h7fff);
        check("peak q ignored", 48'(peak), 48'h0);
    endtask : t_cplx
    task automatic t_fill();
        wr(ADDR_FE_CTL, CTL_RESET);
        @(posedge mclk) ordy <= 1'b0;
        fe_clear();
        repeat (24) src.send(17'h00001, 17'h00000, CPLX_REAL);
        @(negedge mclk) check("fifo full", 48'(rdy_in), 48'h0);
        @(posedge mclk) ordy <= 1'b1;
        wait_rx(16);
        repeat (20) @(negedge mclk);
        check("drained", 48'({ov, rxq.size() >= 16}), 48'h1);
    endtask : t_fill
    task automatic t_rst();
        wr(ADDR_PHASE, 32'h0000_1234);
        @(posedge mclk) nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(negedge mclk);
        check("phase reset", 48'(phase), 48'h0);
    endtask : t_rst
    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs();
        t_sync();
        t_cfg();
        t_nco();
        t_data();
        t_fmt();
        t_cplx(CPLX_NEXT);
        t_cplx(CPLX_TWO);
        t_fill();
        t_rst();
        finish_test();
    end
endmodule : ddcf_front_end_test
